/* dtd_decoder.sv */
// Function
// - 1000100w with addressing byte copies register to reg/mem, 2 clocks reg, 12 clocks memory.
// - 10001110 with a segment field loads that segment register from reg/mem.
// - 10001100 with a segment field stores that segment register to reg/mem.
// - 11010111 is the table lookup byte into the low accumulator, 15 clocks.
// - 10001101 writes the effective address itself into a register, 6 clocks.
// - 11000101 loads a far pointer with the data segment, 26 clocks, memory form only.
// - 11000100 loads a far pointer with the extra segment, 26 clocks, memory form only.
// - 10011111 copies the low flags into the high accumulator, 2 clocks.
// - 10011110 copies the high accumulator into the low flags, 3 clocks.
// - starred memory instructions add 4 clocks when the operand is a word.
// - all counts are minimums assuming prefetched bytes and no wait or hold.
`timescale 1ns/1ps
`default_nettype none
`include "dtd_regs.svh"
module dtd_decoder (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              req_valid,
  input  wire dtd_pkg::dtd_req_t req,
  output logic                   dec_valid,
  output dtd_pkg::dtd_dec_t      dec
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_mem(input logic [7:0] m);
    is_mem = (m[7:6] != `DTD_MOD_REG);
  endfunction : is_mem

  function automatic logic [1:0] disp_of(input logic [7:0] m);
    // direct address form carries two displacement bytes
    if (m[7:6] == `DTD_MOD_NO_DISP)
      disp_of = (m[2:0] == `DTD_RM_DIRECT) ? `DTD_DISP_DIRECT : `DTD_DISP_NONE;
    else if (m[7:6] == `DTD_MOD_REG)
      disp_of = `DTD_DISP_NONE;
    else
      disp_of = m[7:6];
  endfunction : disp_of

  // ----------------------------------------
  // decode
  // ----------------------------------------
  dtd_pkg::dtd_dec_t d;
  logic [7:0]        op;
  logic [7:0]        mr;
  logic              mem;
  logic              star;

  always_comb begin
    op = req.opcode;
    mr = req.modrm;
    mem = is_mem(mr);
    star = 1'b0;
    d = '0;
    d.op = dtd_pkg::DTD_NONE;
    d.reg_sel = mr[5:3];
    d.word = op[0];
    if (op[7:1] == `DTD_OP_COPY_RM) begin
      d.op = dtd_pkg::DTD_COPY_TRANSFER_RM;
      d.mem = mem;
      d.cycles = mem ? `DTD_CYC_COPY_RM : `DTD_CYC_COPY_RR;
      star = 1'b1;
    end else if (op[7:1] == `DTD_OP_COPY_TO_REG) begin
      d.op = dtd_pkg::DTD_COPY_TRANSFER_TO_REG;
      d.mem = mem;
      d.cycles = mem ? `DTD_CYC_COPY_MR : `DTD_CYC_COPY_RR;
      star = 1'b1;
    end else if (op[7:1] == `DTD_OP_COPY_IMM_RM) begin
      d.op = dtd_pkg::DTD_COPY_TRANSFER_IMM;
      d.mem = mem;
      d.illegal = (mr[5:3] != 3'h0);
      d.cycles = mem ? `DTD_CYC_IMM_M : `DTD_CYC_IMM_R;
    end else if (op == `DTD_OP_SEG_LOAD || op == `DTD_OP_SEG_STORE) begin
      d.op = (op == `DTD_OP_SEG_LOAD) ? dtd_pkg::DTD_SEG_LOAD : dtd_pkg::DTD_SEG_STORE;
      d.word = 1'b1;
      d.mem = mem;
      d.illegal = mr[5];
      d.reg_sel = {1'b0, mr[4:3]};
      if (!mem)
        d.cycles = `DTD_CYC_SEG_R;
      else
        d.cycles = (op == `DTD_OP_SEG_LOAD) ? `DTD_CYC_SEG_LOAD_M : `DTD_CYC_SEG_STORE_M;
    end else if (op[7:1] == `DTD_OP_XCHG_RM) begin
      d.op = dtd_pkg::DTD_EXCHANGE;
      d.mem = mem;
      d.cycles = mem ? `DTD_CYC_XCHG_M : `DTD_CYC_XCHG_R;
      star = 1'b1;
    end else if (op == `DTD_OP_TABLE_LOOKUP) begin
      d.op = dtd_pkg::DTD_TABLE_LOOKUP_BYTE;
      d.word = 1'b0;
      d.mem = 1'b1;
      d.cycles = `DTD_CYC_TABLE;
    end else if (op == `DTD_OP_LOAD_EA) begin
      d.op = dtd_pkg::DTD_LOAD_EFFECTIVE_ADDRESS;
      d.word = 1'b1;
      d.illegal = !mem;
      d.cycles = `DTD_CYC_LOAD_EA;
    end else if (op == `DTD_OP_FAR_DS || op == `DTD_OP_FAR_ES) begin
      d.op = (op == `DTD_OP_FAR_DS) ? dtd_pkg::DTD_LOAD_FAR_POINTER_DATA_SEGMENT
                                    : dtd_pkg::DTD_LOAD_FAR_POINTER_EXTRA_SEGMENT;
      d.word = 1'b1;
      d.mem = 1'b1;
      d.illegal = !mem;
      d.cycles = `DTD_CYC_FAR_PTR;
    end else if (op == `DTD_OP_FLAGS_TO_HA) begin
      d.op = dtd_pkg::DTD_FLAGS_TO_HIGH_ACCUMULATOR;
      d.word = 1'b0;
      d.cycles = `DTD_CYC_FLAGS_TO_HA;
    end else if (op == `DTD_OP_HA_TO_FLAGS) begin
      d.op = dtd_pkg::DTD_HIGH_ACCUMULATOR_TO_FLAGS;
      d.word = 1'b0;
      d.cycles = `DTD_CYC_HA_TO_FLAGS;
    end else if (op == `DTD_OP_PUSHF || op == `DTD_OP_POPF) begin
      d.op = (op == `DTD_OP_PUSHF) ? dtd_pkg::DTD_PUSH_FLAGS : dtd_pkg::DTD_POP_FLAGS;
      d.word = 1'b1;
      d.mem = 1'b1;
      d.cycles = (op == `DTD_OP_PUSHF) ? `DTD_CYC_PUSHF : `DTD_CYC_POPF;
    end else if (op[7:1] == `DTD_OP_IN_FIXED || op[7:1] == `DTD_OP_IN_VAR) begin
      d.op = dtd_pkg::DTD_PORT_INPUT;
      d.cycles = op[3] ? `DTD_CYC_IN_VAR : `DTD_CYC_IN_FIXED;
      star = 1'b1;
      d.mem = 1'b1;
    end else if (op[7:1] == `DTD_OP_OUT_FIXED || op[7:1] == `DTD_OP_OUT_VAR) begin
      d.op = dtd_pkg::DTD_PORT_OUTPUT;
      d.cycles = op[3] ? `DTD_CYC_OUT_VAR : `DTD_CYC_OUT_FIXED;
      star = 1'b1;
      d.mem = 1'b1;
    end else begin
      d.word = 1'b0;
      d.illegal = 1'b1;
    end
    // address forming still consumes displacement bytes although no memory is read
    if ((d.mem || d.op == dtd_pkg::DTD_LOAD_EFFECTIVE_ADDRESS)
        && d.op != dtd_pkg::DTD_TABLE_LOOKUP_BYTE && d.op != dtd_pkg::DTD_PORT_INPUT
        && d.op != dtd_pkg::DTD_PORT_OUTPUT && d.op != dtd_pkg::DTD_PUSH_FLAGS
        && d.op != dtd_pkg::DTD_POP_FLAGS)
      d.disp_bytes = disp_of(mr);
    // ports touch i/o, treated as memory transfers for the word penalty
    if (star && d.mem && d.word)
      d.cycles = d.cycles + `DTD_CYC_WORD_ADD;
    // minimums only; wait states and hold are added by the bus side
    if (d.illegal)
      d.cycles = `DTD_CYC_ZERO;
  end

  // ----------------------------------------
  // output register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      dec_valid <= 1'b0;
    else
      dec_valid <= req_valid;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      dec <= '0;
    else if (req_valid)
      dec <= d;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_copy_rm_cycles: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode[7:1] == `DTD_OP_COPY_RM |=> dec.cycles ==
      ($past(req.modrm[7:6]) == 2'h3 ? 8'h02 : ($past(req.opcode[0]) ? 8'h10 : 8'h0c)))
    else $error("copy reg to rm cycle count wrong");
  a_seg_load_op: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode == 8'h8e |=> dec.op == dtd_pkg::DTD_SEG_LOAD && dec.reg_sel[2] == 1'b0)
    else $error("segment load not decoded");
  a_seg_store_op: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode == 8'h8c |=> dec.op == dtd_pkg::DTD_SEG_STORE && dec.word)
    else $error("segment store not decoded");
  a_table_cycles: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode == 8'hd7 |=> dec_valid && dec.cycles == 8'h0f && !dec.word)
    else $error("table lookup cycles wrong");
  a_load_ea_cycles: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode == 8'h8d && req.modrm[7:6] != 2'h3 |=> dec.cycles == 8'h06)
    else $error("effective address cycles wrong");
  a_far_reg_form: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode[7:1] == 7'h62 |=> dec.illegal == ($past(req.modrm[7:6]) == 2'h3))
    else $error("far pointer register form not flagged");
  a_far_cycles: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode[7:1] == 7'h62 && req.modrm[7:6] != 2'h3 |=> dec.cycles == 8'h1a)
    else $error("far pointer cycles wrong");
  a_flag_moves: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode[7:1] == 7'h4f |=> dec.cycles == ($past(req.opcode[0]) ? 8'h02 : 8'h03))
    else $error("flag transfer cycles wrong");
  a_port_word_add: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode[7:1] == 7'h72 |=> dec.cycles == ($past(req.opcode[0]) ? 8'h0e : 8'h0a))
    else $error("port word penalty wrong");
  a_word_select: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode[7:2] == 6'h22 |=> dec.word == $past(req.opcode[0]))
    else $error("size bit not honoured");
  a_reg_form: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && req.opcode[7:2] == 6'h22 |=> dec.mem == ($past(req.modrm[7:6]) != 2'h3))
    else $error("form field misread");
endmodule : dtd_decoder
`default_nettype wire

/* dtd_regs.svh */
`ifndef DTD_REGS_SVH
`define DTD_REGS_SVH
// ----------------------------------------
// opcode encodings
// ----------------------------------------
`define DTD_OP_COPY_RM      7'h44
`define DTD_OP_COPY_TO_REG  7'h45
`define DTD_OP_COPY_IMM_RM  7'h63
`define DTD_OP_SEG_LOAD     8'h8e
`define DTD_OP_SEG_STORE    8'h8c
`define DTD_OP_XCHG_RM      7'h43
`define DTD_OP_TABLE_LOOKUP 8'hd7
`define DTD_OP_LOAD_EA      8'h8d
`define DTD_OP_FAR_DS       8'hc5
`define DTD_OP_FAR_ES       8'hc4
`define DTD_OP_FLAGS_TO_HA  8'h9f
`define DTD_OP_HA_TO_FLAGS  8'h9e
`define DTD_OP_PUSHF        8'h9c
`define DTD_OP_POPF         8'h9d
`define DTD_OP_IN_FIXED     7'h72
`define DTD_OP_IN_VAR       7'h76
`define DTD_OP_OUT_FIXED    7'h73
`define DTD_OP_OUT_VAR      7'h77
// ----------------------------------------
// addressing byte fields
// ----------------------------------------
`define DTD_MOD_REG         2'h3
`define DTD_SEG_MAX         2'h3
`define DTD_MOD_NO_DISP     2'h0
`define DTD_RM_DIRECT       3'h6
`define DTD_DISP_NONE       2'h0
`define DTD_DISP_DIRECT     2'h2
// ----------------------------------------
// cycle counts
// ----------------------------------------
`define DTD_CYC_COPY_RR     8'h02
`define DTD_CYC_COPY_RM     8'h0c
`define DTD_CYC_COPY_MR     8'h09
`define DTD_CYC_IMM_R       8'h0c
`define DTD_CYC_IMM_M       8'h0d
`define DTD_CYC_SEG_R       8'h02
`define DTD_CYC_SEG_LOAD_M  8'h0d
`define DTD_CYC_SEG_STORE_M 8'h0c
`define DTD_CYC_XCHG_R      8'h04
`define DTD_CYC_XCHG_M      8'h11
`define DTD_CYC_TABLE       8'h0f
`define DTD_CYC_LOAD_EA     8'h06
`define DTD_CYC_FAR_PTR     8'h1a
`define DTD_CYC_FLAGS_TO_HA 8'h02
`define DTD_CYC_HA_TO_FLAGS 8'h03
`define DTD_CYC_PUSHF       8'h0d
`define DTD_CYC_POPF        8'h0c
`define DTD_CYC_IN_FIXED    8'h0a
`define DTD_CYC_IN_VAR      8'h08
`define DTD_CYC_OUT_FIXED   8'h09
`define DTD_CYC_OUT_VAR     8'h07
`define DTD_CYC_WORD_ADD    8'h04
`define DTD_CYC_ZERO        8'h00
`endif

/* dtd_pkg.sv */
`default_nettype none
package dtd_pkg;
  typedef enum logic [4:0] {
    DTD_NONE                          = 5'h00,
    DTD_COPY_TRANSFER_RM              = 5'h01,
    DTD_COPY_TRANSFER_TO_REG          = 5'h02,
    DTD_COPY_TRANSFER_IMM             = 5'h03,
    DTD_SEG_LOAD                      = 5'h04,
    DTD_SEG_STORE                     = 5'h05,
    DTD_EXCHANGE                      = 5'h06,
    DTD_TABLE_LOOKUP_BYTE             = 5'h07,
    DTD_LOAD_EFFECTIVE_ADDRESS        = 5'h08,
    DTD_LOAD_FAR_POINTER_DATA_SEGMENT = 5'h09,
    DTD_LOAD_FAR_POINTER_EXTRA_SEGMENT= 5'h0a,
    DTD_FLAGS_TO_HIGH_ACCUMULATOR     = 5'h0b,
    DTD_HIGH_ACCUMULATOR_TO_FLAGS     = 5'h0c,
    DTD_PUSH_FLAGS                    = 5'h0d,
    DTD_POP_FLAGS                     = 5'h0e,
    DTD_PORT_INPUT                    = 5'h0f,
    DTD_PORT_OUTPUT                   = 5'h10
  } dtd_op_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
  } dtd_req_t;

  typedef struct packed {
    dtd_op_t    op;
    logic       word;
    logic       mem;
    logic       illegal;
    logic [1:0] disp_bytes;
    logic [2:0] reg_sel;
    logic [7:0] cycles;
  } dtd_dec_t;
endpackage : dtd_pkg
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
  logic              clk_sys;
  logic              arst_n;
  logic              req_valid;
  dtd_pkg::dtd_req_t req;
  logic              dec_valid;
  dtd_pkg::dtd_dec_t dec;
  logic [14:0]       full;
  logic [12:0]       oc;
  int                n_mismatch;
  int                total_checks;

  assign full = {dec.op, dec.word, dec.mem, dec.cycles};
  assign oc   = {dec.op, dec.cycles};

  dtd_decoder i_dtd_decoder (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .req_valid (req_valid),
    .req       (req),
    .dec_valid (dec_valid),
    .dec       (dec)
  );

  // ----------------------------------------
  // clock and closing
  // ----------------------------------------
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------
  // one request, bounded wait for the answer
  // ----------------------------------------
  task automatic issue(input logic [7:0] opc, input logic [7:0] mr);
    int i;
    // one idle edge so valid is never lowered and raised in one time step
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    req       = {opc, mr};
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    // answer is due one cycle later; the loop only guards against a hang
    for (i = 0; i < 3 && dec_valid !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (dec_valid !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
  endtask : issue

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_copy();
    issue(8'h89, 8'hc0);
    `CHK(full, {dtd_pkg::DTD_COPY_TRANSFER_RM, 1'b1, 1'b0, 8'h02})
    issue(8'h88, 8'h06);
    `CHK(full, {dtd_pkg::DTD_COPY_TRANSFER_RM, 1'b0, 1'b1, 8'h0c})
    `CHK(dec.disp_bytes, 2'h2)
    issue(8'h89, 8'h46);
    `CHK(full, {dtd_pkg::DTD_COPY_TRANSFER_RM, 1'b1, 1'b1, 8'h10})
    `CHK(dec.disp_bytes, 2'h1)
    issue(8'h88, 8'h86);
    `CHK({dec.mem, dec.disp_bytes}, {1'b1, 2'h2})
  endtask : t_copy

  task automatic t_seg();
    issue(8'h8e, 8'hd8);
    `CHK({dec.op, dec.mem, dec.reg_sel}, {dtd_pkg::DTD_SEG_LOAD, 1'b0, 3'h3})
    issue(8'h8e, 8'h06);
    `CHK({dec.op, dec.mem, dec.reg_sel}, {dtd_pkg::DTD_SEG_LOAD, 1'b1, 3'h0})
    issue(8'h8c, 8'h1e);
    `CHK({dec.op, dec.mem, dec.reg_sel}, {dtd_pkg::DTD_SEG_STORE, 1'b1, 3'h3})
    issue(8'h8c, 8'hc8);
    `CHK({dec.op, dec.mem, dec.reg_sel}, {dtd_pkg::DTD_SEG_STORE, 1'b0, 3'h1})
  endtask : t_seg

  task automatic t_single();
    issue(8'hd7, 8'h00);
    `CHK(oc, {dtd_pkg::DTD_TABLE_LOOKUP_BYTE, 8'h0f})
    issue(8'h9f, 8'h00);
    `CHK(oc, {dtd_pkg::DTD_FLAGS_TO_HIGH_ACCUMULATOR, 8'h02})
    issue(8'h9e, 8'h00);
    `CHK(oc, {dtd_pkg::DTD_HIGH_ACCUMULATOR_TO_FLAGS, 8'h03})
  endtask : t_single

  task automatic t_addr_loads();
    issue(8'h8d, 8'h46);
    `CHK(oc, {dtd_pkg::DTD_LOAD_EFFECTIVE_ADDRESS, 8'h06})
    `CHK(dec.disp_bytes, 2'h1)
    issue(8'hc5, 8'h06);
    `CHK({oc, dec.illegal}, {dtd_pkg::DTD_LOAD_FAR_POINTER_DATA_SEGMENT, 8'h1a, 1'b0})
    issue(8'hc5, 8'hd8);
    `CHK({dec.illegal, dec.cycles}, {1'b1, 8'h00})
    issue(8'hc4, 8'h06);
    `CHK({oc, dec.illegal}, {dtd_pkg::DTD_LOAD_FAR_POINTER_EXTRA_SEGMENT, 8'h1a, 1'b0})
    issue(8'hc4, 8'hc0);
    `CHK({dec.illegal, dec.cycles}, {1'b1, 8'h00})
  endtask : t_addr_loads

  task automatic t_other();
    issue(8'h87, 8'hc0);
    `CHK(full, {dtd_pkg::DTD_EXCHANGE, 1'b1, 1'b0, 8'h04})
    issue(8'h87, 8'h06);
    `CHK(full, {dtd_pkg::DTD_EXCHANGE, 1'b1, 1'b1, 8'h15})
    issue(8'h8b, 8'h46);
    `CHK(full, {dtd_pkg::DTD_COPY_TRANSFER_TO_REG, 1'b1, 1'b1, 8'h0d})
    issue(8'hc6, 8'hc0);
    `CHK(full, {dtd_pkg::DTD_COPY_TRANSFER_IMM, 1'b0, 1'b0, 8'h0c})
    issue(8'hc7, 8'h08);
    `CHK({dec.word, dec.illegal, dec.cycles}, {1'b1, 1'b1, 8'h00})
    issue(8'he5, 8'h00);
    `CHK(full, {dtd_pkg::DTD_PORT_INPUT, 1'b1, 1'b1, 8'h0e})
    issue(8'hee, 8'h00);
    `CHK(full, {dtd_pkg::DTD_PORT_OUTPUT, 1'b0, 1'b1, 8'h07})
    issue(8'h00, 8'h00);
    `CHK({oc, dec.illegal}, {dtd_pkg::DTD_NONE, 8'h00, 1'b1})
  endtask : t_other

  // valid held high over two requests; answer must follow each, then drop
  task automatic t_b2b();
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    req       = 16'h9f00;
    @(posedge clk_sys);
    #1;
    req = 16'hd700;
    `CHK({dec_valid, dec.cycles}, {1'b1, 8'h02})
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    `CHK({dec_valid, dec.cycles}, {1'b1, 8'h0f})
    @(posedge clk_sys);
    #1;
    `CHK({dec_valid, dec.cycles}, {1'b0, 8'h0f})
  endtask : t_b2b

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_mismatch   = 0;
    total_checks = 0;
    arst_n       = 1'b0;
    req_valid    = 1'b0;
    req          = 16'h0000;
    repeat (8) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    t_copy();
    t_seg();
    t_single();
    t_addr_loads();
    t_other();
    t_b2b();
    close_out();
  end
endmodule : testbench
`default_nettype wire
